// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "vtms_consts.vh"
module tb;
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg dir_in = 1'b0;
  reg [6:0] reg_addr = 7'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_we = 1'b0;
  reg reg_re = 1'b0;
  reg quiet_en = 1'b1;
  reg [31:0] flags = 32'hA5A50F0F;
  reg [7:0] ofs = 8'h5A;
  reg [7:0] grad = 8'hC3;
  reg run = 1'b0;
  reg [7:0] period = 8'h28;
  reg cnt_on = 1'b0;
  wire step_in, rvalid, hyst_sel, index_out, mdir;
  wire [31:0] rdata;
  wire [9:0] pos;
  integer err_count = 0;
  integer compares = 0;
  integer nsteps = 0;
  integer nidx = 0;
  always #10 mclk = ~mclk;
  always @(posedge step_in) nsteps = nsteps + 1;
  always @(posedge mclk) if (cnt_on && index_out === 1'b1) nidx = nidx + 1;
  vtms_host_model vtms_host_model_i (.mclk(mclk), .run(run),
    .period(period), .step_out(step_in));
  vtms_core vtms_core_i (.mclk(mclk), .resetn(resetn), .step_in(step_in),
    .dir_in(dir_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_r(rdata),
    .reg_rvalid_r(rvalid), .quiet_chopper_en(quiet_en),
    .driver_status_flags(flags), .pwm_amplitude_result(17'h0),
    .auto_pwm_offset(ofs), .auto_pwm_gradient(grad),
    .hyst_chopper_sel_r(hyst_sel), .index_out_r(index_out),
    .motion_dir_r(mdir), .wave_table_position_r(pos), .phase_a_current(),
    .phase_b_current(), .chopper_configuration_r(),
    .quiet_pwm_configuration_r());
  task stop_test;
  begin
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [6:0] a, input [31:0] d);
  begin
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
  end
  endtask
  task rc(input [6:0] a, input [31:0] e);
    integer n;
  begin
    @(negedge mclk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge mclk);
    reg_re = 1'b0;
    n = 0;
    // answer is due one edge after the strobe; bounded wait
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n = n + 1;
    end
    chk(rdata, e);
  end
  endtask
  task t_reset;
  begin
    rc(`VTMS_ADDR_CHOPCFG, `VTMS_CHOPCFG_RST);
    rc(`VTMS_ADDR_QUIET_PWMCFG, `VTMS_QUIET_PWMCFG_RST);
    rc(`VTMS_ADDR_STEP_INTERVAL, 32'h000FFFFF);
    rc(`VTMS_ADDR_PHASE_CUR, 32'h00FF0000);
    rc(7'h01, 32'h0);
  end
  endtask
  task t_ro;
  begin
    wr(`VTMS_ADDR_WAVE_POS, 32'h155);
    wr(`VTMS_ADDR_STEP_INTERVAL, 32'h00123);
    rc(`VTMS_ADDR_WAVE_POS, 32'h0);
    rc(`VTMS_ADDR_STEP_INTERVAL, 32'h000FFFFF);
    rc(`VTMS_ADDR_DRV_FLAGS, 32'hA5A50F0F);
    rc(`VTMS_ADDR_PWM_AUTO, 32'h00C3005A);
    wr(`VTMS_ADDR_CHOPCFG, 32'h00000053);
    rc(`VTMS_ADDR_CHOPCFG, 32'h00000053);
  end
  endtask
  task t_step;
    reg [9:0] p0;
  begin
    nsteps = 0;
    run = 1'b1;
    repeat (200) @(negedge mclk);
    run = 1'b0;
    repeat (4) @(negedge mclk);
    rc(`VTMS_ADDR_STEP_INTERVAL, 32'd40);
    p0 = nsteps;
    rc(`VTMS_ADDR_WAVE_POS, {22'h0, p0});
    dir_in = 1'b1;
    nsteps = 0;
    run = 1'b1;
    repeat (200) @(negedge mclk);
    run = 1'b0;
    repeat (4) @(negedge mclk);
    p0 = p0 - nsteps;
    chk({22'h0, pos}, {22'h0, p0});
  end
  endtask
  task thr_at(input [7:0] p, input e);
  begin
    period = p;
    run = 1'b1;
    repeat (4 * p) @(negedge mclk);
    chk({31'h0, hyst_sel}, {31'h0, e});
  end
  endtask
  task t_thr;
  begin
    // threshold 64: upper compare 64, lower 64*15/16-1 = 59
    wr(`VTMS_ADDR_QUIET_THRS, 32'd64);
    thr_at(8'd40, 1'b1);
    thr_at(8'd63, 1'b1);
    thr_at(8'd64, 1'b0);
    thr_at(8'd59, 1'b0);
    thr_at(8'd58, 1'b1);
    quiet_en = 1'b0;
    thr_at(8'd70, 1'b1);
    quiet_en = 1'b1;
    wr(`VTMS_ADDR_QUIET_THRS, 32'd0);
    thr_at(8'd40, 1'b0);
  end
  endtask
  task vel_win(input [23:0] v, input [9:0] d, input s);
    reg [9:0] p0;
  begin
    wr(`VTMS_ADDR_INT_VELOCITY, {8'h00, v});
    repeat (8) @(negedge mclk);
    p0 = pos;
    nidx = 0;
    cnt_on = 1'b1;
    repeat (400) @(negedge mclk);
    cnt_on = 1'b0;
    chk(nidx, 32'd100);
    p0 = pos - p0;
    chk({22'h0, p0}, {22'h0, d});
    chk({31'h0, mdir}, {31'h0, s});
  end
  endtask
  task t_vel;
  begin
    // steps keep arriving and must be ignored; 2^22 gives a step per 4 clocks
    vel_win(24'h400000, 10'd100, 1'b0);
    vel_win(24'hC00000, 10'h39C, 1'b1);
    wr(`VTMS_ADDR_INT_VELOCITY, 32'h0);
    run = 1'b0;
  end
  endtask
  task t_mres;
    reg [9:0] p0;
  begin
    // four microsteps per step pulse, interval scaled back to 1/256 steps
    dir_in = 1'b0;
    period = 8'd40;
    wr(`VTMS_ADDR_CHOPCFG, 32'h02000000);
    p0 = pos;
    nsteps = 0;
    run = 1'b1;
    repeat (200) @(negedge mclk);
    run = 1'b0;
    repeat (4) @(negedge mclk);
    rc(`VTMS_ADDR_STEP_INTERVAL, 32'd10);
    chk({22'h0, pos}, {22'h0, p0 + {nsteps[7:0], 2'b00}});
    // double edge: both edges of each pulse carry four microsteps
    wr(`VTMS_ADDR_CHOPCFG, 32'h22000000);
    p0 = pos;
    nsteps = 0;
    run = 1'b1;
    repeat (200) @(negedge mclk);
    run = 1'b0;
    repeat (4) @(negedge mclk);
    chk({22'h0, pos}, {22'h0, p0 + {nsteps[6:0], 3'b000}});
  end
  endtask
  initial
  begin
    #1000000;
    err_count = err_count + 1;
    stop_test;
  end
  initial
  begin
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    t_reset;
    t_ro;
    t_step;
    t_thr;
    t_vel;
    t_mres;
    stop_test;
  end
endmodule // tb

// ==== bench/vtms_chk.sv ====
`timescale 1ns/1ps
module vtms_chk
(
  // clock and reset
  input wire mclk,
  input wire resetn,
  // register port
  input wire [6:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  input wire [31:0] reg_rdata_r,
  input wire reg_rvalid_r,
  // readback and outputs
  input wire [7:0] auto_pwm_offset,
  input wire [7:0] auto_pwm_gradient,
  input wire [9:0] wave_table_position_r,
  input wire [8:0] phase_a_current,
  input wire [8:0] phase_b_current,
  input wire [31:0] chopper_configuration_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  property p_rd_ans;
    reg_re |=> reg_rvalid_r;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_hold;
    !reg_rvalid_r |-> $stable(reg_rdata_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_pos_rd;
    reg_rvalid_r && $past(reg_addr) == 7'h6A
      |-> reg_rdata_r == {22'h0, $past(wave_table_position_r)};
  endproperty
  a_pos_rd: assert property (p_pos_rd) else $error("bad position");
  property p_cur_rd;
    reg_rvalid_r && $past(reg_addr) == 7'h6B |-> reg_rdata_r ==
      {{7{$past(phase_b_current[8])}}, $past(phase_b_current),
      {7{$past(phase_a_current[8])}}, $past(phase_a_current)};
  endproperty
  a_cur_rd: assert property (p_cur_rd) else $error("bad current");
  property p_auto_rd;
    reg_rvalid_r && $past(reg_addr) == 7'h72 |-> reg_rdata_r ==
      {8'h0, $past(auto_pwm_gradient), 8'h0, $past(auto_pwm_offset)};
  endproperty
  a_auto_rd: assert property (p_auto_rd) else $error("bad tuning");
  property p_wo_rd;
    reg_rvalid_r && ($past(reg_addr) == 7'h13 || $past(reg_addr) == 7'h22)
      |-> reg_rdata_r == 32'h0;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("write-only read not 0");
  property p_wave_zero;
    wave_table_position_r == 10'h000 [*2]
      |-> phase_a_current == 9'h000 && phase_b_current == 9'h0FF;
  endproperty
  a_wave_zero: assert property (p_wave_zero) else $error("bad table");
  property p_chop_wr;
    reg_we && reg_addr == 7'h6C |=> chopper_configuration_r == $past(reg_wdata);
  endproperty
  a_chop_wr: assert property (p_chop_wr) else $error("config not written");
endmodule // vtms_chk
bind vtms_core vtms_chk vtms_chk_i (.mclk(mclk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
  .auto_pwm_offset(auto_pwm_offset), .auto_pwm_gradient(auto_pwm_gradient),
  .wave_table_position_r(wave_table_position_r),
  .phase_a_current(phase_a_current), .phase_b_current(phase_b_current),
  .chopper_configuration_r(chopper_configuration_r));

// ==== bench/vtms_host_model.sv ====
`timescale 1ns/1ps
// host step source: one-cycle step pulse every period cycles
module vtms_host_model
(
  // clock
  input wire mclk,
  // control
  input wire run,
  input wire [7:0] period,
  // step pin
  output reg step_out
);
  reg [7:0] cnt_r = 8'h00;
  initial step_out = 1'b0;
  // period of 2 or more keeps one low sample between steps
  always @(negedge mclk)
  begin
    cnt_r <= (run && cnt_r + 8'h01 < period) ? cnt_r + 8'h01 : 8'h00;
    step_out <= run && cnt_r == 8'h00;
  end
endmodule // vtms_host_model

// ==== rtl/vtms_consts.vh ====
`ifndef VTMS_CONSTS_VH
`define VTMS_CONSTS_VH

// register addresses (7-bit register address of a datagram)
`define VTMS_ADDR_STEP_INTERVAL 7'h12
`define VTMS_ADDR_QUIET_THRS 7'h13
`define VTMS_ADDR_INT_VELOCITY 7'h22
`define VTMS_ADDR_WAVE_POS 7'h6A
`define VTMS_ADDR_PHASE_CUR 7'h6B
`define VTMS_ADDR_CHOPCFG 7'h6C
`define VTMS_ADDR_DRV_FLAGS 7'h6F
`define VTMS_ADDR_QUIET_PWMCFG 7'h70
`define VTMS_ADDR_PWM_AMPL 7'h71
`define VTMS_ADDR_PWM_AUTO 7'h72

// reset values and clamp limits
`define VTMS_CHOPCFG_RST 32'h10000053
`define VTMS_QUIET_PWMCFG_RST 32'hC10D0024
`define VTMS_INTERVAL_MAX 20'hFFFFF
`define VTMS_VEL_NEG_LIMIT 24'h800001

// field positions
`define VTMS_CHOP_MRES_LSB 24
`define VTMS_CHOP_MRES_MSB 27
`define VTMS_CHOP_DEDGE 29
`define VTMS_PHASE_B_CURRENT_LSB 16
`define VTMS_AUTO_GRAD_LSB 16

// limits: microstep resolution field capped at 8, phase B offset in table entries
`define VTMS_MRES_MAX 4'h8
`define VTMS_PHASE_B_OFS 10'h100

`endif

// ==== rtl/vtms_core.v ====
`timescale 1ns/1ps
`include "vtms_consts.vh"
module vtms_core
#(
  parameter ACC_W = 24,
  parameter PER_W = 28
)
(
  // clock and reset
  input wire mclk,
  input wire resetn,
  // step and direction from host
  input wire step_in,
  input wire dir_in,
  // register port from the datagram decoder
  input wire [6:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [31:0] reg_rdata_r,
  output reg reg_rvalid_r,
  // inputs from chopper and regulation logic
  input wire quiet_chopper_en,
  input wire [31:0] driver_status_flags,
  input wire [16:0] pwm_amplitude_result,
  input wire [7:0] auto_pwm_offset,
  input wire [7:0] auto_pwm_gradient,
  // outputs to chopper and pins
  output reg hyst_chopper_sel_r,
  output reg index_out_r,
  output reg motion_dir_r,
  output reg [9:0] wave_table_position_r,
  output wire [8:0] phase_a_current,
  output wire [8:0] phase_b_current,
  output reg [31:0] chopper_configuration_r,
  output reg [31:0] quiet_pwm_configuration_r
);

  reg [19:0] step_interval_r;
  reg [19:0] quiet_chopper_threshold_r;
  reg [23:0] internal_velocity_r;
  reg [ACC_W-1:0] vel_acc_r;
  reg step_d_r;
  reg gen_pulse_r;
  reg [PER_W-1:0] per_cnt_r;
  reg [3:0] last_shift_r;

  wire [3:0] mres_raw;
  wire [3:0] mres;
  wire dedge;
  wire vel_mode;
  wire step_edge;
  wire ext_event;
  wire motion_event;
  wire [3:0] event_shift;
  wire [9:0] ext_inc;
  wire ext_dir;
  wire [23:0] vel_mag;
  wire [ACC_W:0] acc_sum;
  wire [PER_W-1:0] per_shifted;
  wire [PER_W-1:0] idle_shifted;
  wire [19:0] lower_cmp;
  wire [9:0] pos_b;

  function [19:0] vtms_sat20;
    input [PER_W-1:0] val;
    begin
      if (val > {{(PER_W-20){1'b0}}, `VTMS_INTERVAL_MAX})
        vtms_sat20 = `VTMS_INTERVAL_MAX;
      else
        vtms_sat20 = val[19:0];
    end
  endfunction

  // register address decode, used by the write and the read path
  function vtms_hit;
    input [6:0] addr;
    input [6:0] target;
    begin
      vtms_hit = (addr == target);
    end
  endfunction

  // configuration fields
  assign mres_raw =
    chopper_configuration_r[`VTMS_CHOP_MRES_MSB:`VTMS_CHOP_MRES_LSB];
  assign mres = (mres_raw > `VTMS_MRES_MAX) ? `VTMS_MRES_MAX : mres_raw;
  assign dedge = chopper_configuration_r[`VTMS_CHOP_DEDGE];

  // step input edge, both edges when double edge stepping is set
  assign step_edge = dedge ? (step_in ^ step_d_r) : (step_in & ~step_d_r);

  assign vel_mode = (internal_velocity_r != 24'h000000);
  // external steps are ignored while the generator owns the motor
  assign ext_event = step_edge & ~vel_mode;
  assign motion_event = vel_mode ? gen_pulse_r : ext_event;
  assign event_shift = vel_mode ? 4'h0 : mres;
  assign ext_inc = 10'h001 << mres;
  assign ext_dir = dir_in;

  // velocity generator: phase accumulator, carry is one microstep
  assign vel_mag = internal_velocity_r[23] ?
    (24'h000000 - internal_velocity_r) : internal_velocity_r;
  assign acc_sum = {1'b0, vel_acc_r} + {1'b0, vel_mag[ACC_W-1:0]};

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      vel_acc_r <= {ACC_W{1'b0}};
      gen_pulse_r <= 1'b0;
    end
    else if (vel_mode)
    begin
      vel_acc_r <= acc_sum[ACC_W-1:0];
      gen_pulse_r <= acc_sum[ACC_W];
    end
    else
    begin
      vel_acc_r <= {ACC_W{1'b0}};
      gen_pulse_r <= 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      step_d_r <= 1'b0;
    else
      step_d_r <= step_in;
  end

  // direction and index pin
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      motion_dir_r <= 1'b0;
      index_out_r <= 1'b0;
    end
    else
    begin
      if (vel_mode)
        motion_dir_r <= internal_velocity_r[23];
      else
        motion_dir_r <= ext_dir;
      if (vel_mode)
        index_out_r <= gen_pulse_r;
      else
        index_out_r <= (wave_table_position_r == 10'h000);
    end
  end

  // wave table position, phase B reads 256 entries ahead
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wave_table_position_r <= 10'h000;
    else if (motion_event)
    begin
      if (vel_mode)
      begin
        if (internal_velocity_r[23])
          wave_table_position_r <= wave_table_position_r - 10'h001;
        else
          wave_table_position_r <= wave_table_position_r + 10'h001;
      end
      else if (ext_dir)
        wave_table_position_r <= wave_table_position_r - ext_inc;
      else
        wave_table_position_r <= wave_table_position_r + ext_inc;
    end
  end

  assign pos_b = wave_table_position_r + `VTMS_PHASE_B_OFS;

  vtms_wave_rom u_wave_rom
  (
    .mclk(mclk),
    .resetn(resetn),
    .addr_a(wave_table_position_r),
    .addr_b(pos_b),
    .data_a_r(phase_a_current),
    .data_b_r(phase_b_current)
  );

  // step interval measurement; period spans one event, scaled to
  // 1/256 microsteps by the microsteps the event carried
  assign per_shifted = per_cnt_r >> event_shift;
  assign idle_shifted = per_cnt_r >> last_shift_r;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      per_cnt_r <= {PER_W{1'b0}};
      last_shift_r <= 4'h0;
      step_interval_r <= `VTMS_INTERVAL_MAX;
    end
    else if (motion_event)
    begin
      per_cnt_r <= {{(PER_W-1){1'b0}}, 1'b1};
      last_shift_r <= event_shift;
      step_interval_r <= vtms_sat20(per_shifted);
    end
    else
    begin
      // counter holds at all ones so a long stop never wraps short
      if (per_cnt_r != {PER_W{1'b1}})
        per_cnt_r <= per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
      if (idle_shifted > {{(PER_W-20){1'b0}}, `VTMS_INTERVAL_MAX})
        step_interval_r <= `VTMS_INTERVAL_MAX;
    end
  end

  // quiet chopper threshold with hysteresis; a larger interval means
  // a slower motor, so the quiet chopper sits above the threshold
  assign lower_cmp = quiet_chopper_threshold_r -
    {4'h0, quiet_chopper_threshold_r[19:4]} - 20'h00001;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      hyst_chopper_sel_r <= 1'b0;
    else if (!quiet_chopper_en)
      hyst_chopper_sel_r <= 1'b1;
    else if (quiet_chopper_threshold_r == 20'h00000)
      hyst_chopper_sel_r <= 1'b0;
    else if (!hyst_chopper_sel_r)
    begin
      if (step_interval_r < lower_cmp)
        hyst_chopper_sel_r <= 1'b1;
    end
    else if (step_interval_r >= quiet_chopper_threshold_r)
      hyst_chopper_sel_r <= 1'b0;
  end

  // register writes; read-only addresses ignore writes
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      quiet_chopper_threshold_r <= 20'h00000;
      internal_velocity_r <= 24'h000000;
      chopper_configuration_r <= `VTMS_CHOPCFG_RST;
      quiet_pwm_configuration_r <= `VTMS_QUIET_PWMCFG_RST;
    end
    else if (reg_we)
    begin
      if (vtms_hit(reg_addr, `VTMS_ADDR_QUIET_THRS))
        quiet_chopper_threshold_r <= reg_wdata[19:0];
      if (vtms_hit(reg_addr, `VTMS_ADDR_INT_VELOCITY))
      begin
        // the most negative code is not a legal speed
        if (reg_wdata[23:0] == 24'h800000)
          internal_velocity_r <= `VTMS_VEL_NEG_LIMIT;
        else
          internal_velocity_r <= reg_wdata[23:0];
      end
      if (vtms_hit(reg_addr, `VTMS_ADDR_CHOPCFG))
        chopper_configuration_r <= reg_wdata;
      if (vtms_hit(reg_addr, `VTMS_ADDR_QUIET_PWMCFG))
        quiet_pwm_configuration_r <= reg_wdata;
    end
  end

  // register reads; write-only and unmapped addresses read zero,
  // and a read changes nothing in the motor path
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata_r <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_re;
      if (reg_re)
      begin
        reg_rdata_r <= 32'h00000000;
        if (vtms_hit(reg_addr, `VTMS_ADDR_STEP_INTERVAL))
          reg_rdata_r <= {12'h000, step_interval_r};
        if (vtms_hit(reg_addr, `VTMS_ADDR_WAVE_POS))
          reg_rdata_r <= {22'h000000, wave_table_position_r};
        if (vtms_hit(reg_addr, `VTMS_ADDR_PHASE_CUR))
          reg_rdata_r <= {{7{phase_b_current[8]}}, phase_b_current,
            {7{phase_a_current[8]}}, phase_a_current};
        if (vtms_hit(reg_addr, `VTMS_ADDR_CHOPCFG))
          reg_rdata_r <= chopper_configuration_r;
        if (vtms_hit(reg_addr, `VTMS_ADDR_DRV_FLAGS))
          reg_rdata_r <= driver_status_flags;
        if (vtms_hit(reg_addr, `VTMS_ADDR_QUIET_PWMCFG))
          reg_rdata_r <= quiet_pwm_configuration_r;
        if (vtms_hit(reg_addr, `VTMS_ADDR_PWM_AMPL))
          reg_rdata_r <= {15'h0000, pwm_amplitude_result};
        if (vtms_hit(reg_addr, `VTMS_ADDR_PWM_AUTO))
          reg_rdata_r <= {8'h00, auto_pwm_gradient, 8'h00,
            auto_pwm_offset};
      end
    end
  end

endmodule // vtms_core

// ==== rtl/vtms_wave_rom.v ====
`timescale 1ns/1ps
// two-port sine wave table, 1024 entries, signed 9-bit, registered reads
module vtms_wave_rom
(
  // clock and reset
  input wire mclk,
  input wire resetn,
  // read ports
  input wire [9:0] addr_a,
  input wire [9:0] addr_b,
  output reg [8:0] data_a_r,
  output reg [8:0] data_b_r
);

  // quarter wave by a parabola; peak 255, saves a stored table
  function [8:0] vtms_sine;
    input [9:0] addr;
    reg [8:0] i;
    reg [17:0] prod;
    reg [8:0] mag;
    begin
      i = addr[8] ? (9'h100 - {1'b0, addr[7:0]}) : {1'b0, addr[7:0]};
      prod = i * (9'h1FF - i + 9'h001);
      mag = (prod[17:8] > 10'h0FF) ? 9'h0FF : prod[16:8];
      vtms_sine = addr[9] ? (9'h000 - mag) : mag;
    end
  endfunction

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_a_r <= 9'h000;
      data_b_r <= 9'h000;
    end
    else
    begin
      data_a_r <= vtms_sine(addr_a);
      data_b_r <= vtms_sine(addr_b);
    end
  end

endmodule // vtms_wave_rom
